//--- verilog/ecsd_decoder.sv
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module ecsd_decoder
	import ecsd_pkg::*;
#(
	parameter int CARDS = ECSD_CARDS
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// processor byte cycle, same clock domain
	input  wire logic             cyc_i,
	input  wire ecsd_req_s        req_i,
	output logic                  ack_o,
	output logic                  win_hit_o,
	output logic                  gen_hit_o,
	output logic [7:0]            rdata_o,
	// memory management logic
	input  wire logic             port_b_perm_i,
	input  wire logic [CARDS-1:0] card_open_i,
	// backplane toward cards
	output logic                  permit_n_o,
	output ecsd_stb_s             stb_o,
	output logic [5:0]            card_sel_o,
	output logic                  chan_sel_o,
	output logic [1:0]            strobe_num_o,
	output logic [7:0]            wdata_o,
	output logic                  byte_clk_o,
	input  wire logic [7:0]       card_rdata_i,
	input  wire logic [3:0]       presence_n_i,
	// interrupts from the backplane
	input  wire logic [3:0]       direct_irq_n_i,
	input  wire logic             interrupt_request_level_five_i,
	input  wire logic             interrupt_request_level_two_i,
	output logic [3:0]            direct_level_o,
	output logic                  interrupt_request_level_zero_o,
	output logic                  interrupt_request_level_five_o,
	output logic                  interrupt_request_level_two_o,
	// shared DMA channel 7
	input  wire logic             dma_req_floppy_i,
	input  wire logic             dma_req_card_i,
	input  wire logic             dma_done_i,
	output logic                  dma_grant_floppy_o,
	output logic                  dma_grant_card_o
);

	// backplane inputs pass two flops before use
	logic [7:0] rd_s1_q, rd_s2_q;
	logic [3:0] pr_s1_q, pr_s2_q;
	logic [3:0] dir_s1_q, dir_s2_q;
	logic [1:0] ix_s1_q, ix_s2_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_s1_q  <= 8'h00;
			rd_s2_q  <= 8'h00;
			pr_s1_q  <= 4'hf;
			pr_s2_q  <= 4'hf;
			dir_s1_q <= 4'hf;
			dir_s2_q <= 4'hf;
			ix_s1_q  <= 2'h3;
			ix_s2_q  <= 2'h3;
		end else begin
			rd_s1_q  <= card_rdata_i;
			rd_s2_q  <= rd_s1_q;
			pr_s1_q  <= presence_n_i;
			pr_s2_q  <= pr_s1_q;
			dir_s1_q <= direct_irq_n_i;
			dir_s2_q <= dir_s1_q;
			ix_s1_q  <= {interrupt_request_level_five_i,
				interrupt_request_level_two_i};
			ix_s2_q  <= ix_s1_q;
		end
	end

	// address decode, shared by window and general area checks
	function automatic logic in_range(input logic [23:0] a,
			input logic [23:0] lo, input logic [23:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	logic [23:0] off;
	logic [5:0]  slot;
	logic        spec;
	logic [2:0]  stb_num;
	logic        win_ok;
	logic        allowed;

	always_comb begin
		off     = req_i.addr - ECSD_WIN_LO;
		slot    = off[ECSD_SLOT_LSB +: 6];
		spec    = off[ECSD_SPEC_BIT];
		stb_num = off[ECSD_STB_LSB +: 3];
		// odd byte, offset bits 1..0 below the strobe field clear; bits above it unchecked
		win_ok  = in_range(req_i.addr, ECSD_WIN_LO, ECSD_WIN_HI)
			&& req_i.addr[0] && (off[1:0] == 2'b00);
		// protection per card in user mode
		allowed = !req_i.user
			|| (port_b_perm_i && card_open_i[slot]);
	end

	ecsd_state_e state_q, state_d;
	ecsd_stb_s   stb_q, stb_d;
	logic        ack_q, ack_d, hit_q, hit_d, gen_q, gen_d;
	logic        perm_n_q, perm_n_d, bclk_q, bclk_d, chan_q, chan_d;
	logic [5:0]  sel_q, sel_d;
	logic [1:0]  snum_q, snum_d;
	logic [7:0]  rdat_q, rdat_d, wdat_q, wdat_d;
	logic        rd_q, rd_d, sp_q, sp_d, sc_q, sc_d, wt_q, wt_d;

	// cycle sequencer: idle, data phase with strobe, done with ack
	always_comb begin
		state_d  = state_q;
		stb_d    = stb_q;
		ack_d    = 1'b0;
		hit_d    = hit_q;
		gen_d    = gen_q;
		perm_n_d = perm_n_q;
		bclk_d   = 1'b0;
		chan_d   = chan_q;
		sel_d    = sel_q;
		snum_d   = snum_q;
		rdat_d   = rdat_q;
		wdat_d   = wdat_q;
		rd_d     = rd_q;
		sp_d     = sp_q;
		sc_d     = sc_q;
		wt_d     = 1'b0;
		unique case (state_q)
			ECSD_IDLE: begin
				stb_d    = ECSD_STB_IDLE;
				perm_n_d = 1'b1;
				hit_d    = 1'b0;
				gen_d    = 1'b0;
				if (cyc_i) begin
					perm_n_d = !(!req_i.user || port_b_perm_i);
					gen_d    = in_range(req_i.addr, ECSD_GEN_LO,
						ECSD_GEN_HI);
					hit_d    = win_ok && allowed;
					sel_d    = slot;
					chan_d   = off[ECSD_CHAN_BIT];
					snum_d   = stb_num[1:0];
					wdat_d   = req_i.wdata;
					rd_d     = req_i.rd;
					sp_d     = spec;
					sc_d     = (stb_num >= ECSD_STB_SCAN);
					if (win_ok && allowed) begin
						bclk_d = 1'b1;
						state_d = ECSD_DATA;
						if (spec) begin
							if (stb_num >= ECSD_STB_SCAN)
								stb_d.scanner_strobe_n = 1'b0;
						end else begin
							unique case (ecsd_stb_e'(stb_num))
								ECSD_STB_DATA:
									if (req_i.rd)
										stb_d.read_data_strobe_n = 1'b0;
									else
										stb_d.write_data_strobe_n = 1'b0;
								ECSD_STB_STAT:
									if (req_i.rd)
										stb_d.status_strobe_n = 1'b0;
								ECSD_STB_AUX:
									if (req_i.rd)
										stb_d.read_aux_strobe_n = 1'b0;
									else
										stb_d.control_pulse_one_n = 1'b0;
								ECSD_STB_CTL2:
									if (!req_i.rd)
										stb_d.control_pulse_two_n = 1'b0;
								ECSD_STB_CTL3:
									if (!req_i.rd)
										stb_d.control_pulse_three_n = 1'b0;
								ECSD_STB_CTL4:
									if (!req_i.rd)
										stb_d.control_pulse_four_n = 1'b0;
								ECSD_STB_NONE6, ECSD_STB_NONE7: ;
							endcase
						end
					end else begin
						// refused or foreign cycle ends at once
						ack_d   = 1'b1;
						rdat_d  = 8'h00;
						state_d = ECSD_IDLE;
					end
				end
			end
			ECSD_DATA: begin
				// two-flop read data lags two edges, so the strobe
				// stands three edges before done may take the data
				wt_d = 1'b1;
				if (wt_q)
					state_d = ECSD_DONE;
			end
			ECSD_DONE: begin
				if (sp_q && rd_q && !sc_q)
					rdat_d = {2'b00, pr_s2_q, 2'b00};
				else
					rdat_d = rd_s2_q;
				stb_d    = ECSD_STB_IDLE;
				perm_n_d = 1'b1;
				ack_d    = 1'b1;
				state_d  = ECSD_IDLE;
			end
			default: state_d = ECSD_IDLE;
		endcase
	end

	// cycle state registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q  <= ECSD_IDLE;
			stb_q    <= ECSD_STB_IDLE;
			ack_q    <= 1'b0;
			hit_q    <= 1'b0;
			gen_q    <= 1'b0;
			perm_n_q <= 1'b1;
			bclk_q   <= 1'b0;
			chan_q   <= 1'b0;
			sel_q    <= 6'h00;
			snum_q   <= 2'h0;
			rdat_q   <= 8'h00;
			wdat_q   <= 8'h00;
			rd_q     <= 1'b0;
			sp_q     <= 1'b0;
			sc_q     <= 1'b0;
			wt_q     <= 1'b0;
		end else begin
			state_q  <= state_d;
			stb_q    <= stb_d;
			ack_q    <= ack_d;
			hit_q    <= hit_d;
			gen_q    <= gen_d;
			perm_n_q <= perm_n_d;
			bclk_q   <= bclk_d;
			chan_q   <= chan_d;
			sel_q    <= sel_d;
			snum_q   <= snum_d;
			rdat_q   <= rdat_d;
			wdat_q   <= wdat_d;
			rd_q     <= rd_d;
			sp_q     <= sp_d;
			sc_q     <= sc_d;
			wt_q     <= wt_d;
		end
	end

	// interrupt folding and DMA channel ownership
	logic [3:0] dlev_d, dlev_q;
	logic       interrupt_request_level_zero_d, interrupt_request_level_zero_q, interrupt_request_level_five_q, interrupt_request_level_two_q;
	logic       gf_d, gf_q, gc_d, gc_q;

	always_comb begin
		dlev_d = ~dir_s2_q;
		interrupt_request_level_zero_d = |dlev_d;
		gf_d   = gf_q;
		gc_d   = gc_q;
		// one owner at a time; floppy wins a tie
		if (dma_done_i) begin
			gf_d = 1'b0;
			gc_d = 1'b0;
		end else if (!gf_q && !gc_q) begin
			gf_d = dma_req_floppy_i;
			gc_d = dma_req_card_i && !dma_req_floppy_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dlev_q <= 4'h0;
			interrupt_request_level_zero_q <= 1'b0;
			interrupt_request_level_five_q <= 1'b0;
			interrupt_request_level_two_q <= 1'b0;
			gf_q   <= 1'b0;
			gc_q   <= 1'b0;
		end else begin
			dlev_q <= dlev_d;
			interrupt_request_level_zero_q <= interrupt_request_level_zero_d;
			interrupt_request_level_five_q <= !ix_s2_q[1];
			interrupt_request_level_two_q <= !ix_s2_q[0];
			gf_q   <= gf_d;
			gc_q   <= gc_d;
		end
	end

	// outputs straight from flops
	assign ack_o                          = ack_q;
	assign win_hit_o                      = hit_q;
	assign gen_hit_o                      = gen_q;
	assign rdata_o                        = rdat_q;
	assign permit_n_o                     = perm_n_q;
	assign stb_o                          = stb_q;
	assign card_sel_o                     = sel_q;
	assign chan_sel_o                     = chan_q;
	assign strobe_num_o                   = snum_q;
	assign wdata_o                        = wdat_q;
	assign byte_clk_o                     = bclk_q;
	assign direct_level_o                 = dlev_q;
	assign interrupt_request_level_zero_o = interrupt_request_level_zero_q;
	assign interrupt_request_level_five_o = interrupt_request_level_five_q;
	assign interrupt_request_level_two_o  = interrupt_request_level_two_q;
	assign dma_grant_floppy_o             = gf_q;
	assign dma_grant_card_o               = gc_q;

endmodule : ecsd_decoder

`default_nettype wire

//--- pkg/ecsd_pkg.sv
package ecsd_pkg;

	// expansion window and general expansion area (24-bit byte addresses)
	localparam logic [23:0] ECSD_WIN_LO     = 24'hFE_0001;
	localparam logic [23:0] ECSD_WIN_HI     = 24'hFF_FFFF;
	localparam logic [23:0] ECSD_GEN_LO     = 24'h40_0000;
	localparam logic [23:0] ECSD_GEN_HI     = 24'h7F_FFFF;
	// card slot pitch and field positions inside the window offset
	localparam logic [23:0] ECSD_SLOT_PITCH = 24'h00_0800;
	localparam int          ECSD_SLOT_LSB   = 11;
	localparam int          ECSD_SPEC_BIT   = 6;
	localparam int          ECSD_CHAN_BIT   = 7;
	localparam int          ECSD_STB_LSB    = 2;
	localparam logic [2:0]  ECSD_STB_SCAN   = 3'h4;
	// presence lines sit on data bits 5..2
	localparam int          ECSD_PRES_LSB   = 2;
	// management port B bit that permits user-mode expansion cycles
	localparam int          ECSD_PERM_BIT   = 1;
	localparam int          ECSD_CARDS      = 64;
	localparam int          ECSD_DMA_CHAN   = 7;

	// strobe number decode
	typedef enum logic [2:0] {
		ECSD_STB_DATA  = 3'b000,
		ECSD_STB_STAT  = 3'b001,
		ECSD_STB_AUX   = 3'b010,
		ECSD_STB_CTL2  = 3'b011,
		ECSD_STB_CTL3  = 3'b100,
		ECSD_STB_CTL4  = 3'b101,
		ECSD_STB_NONE6 = 3'b110,
		ECSD_STB_NONE7 = 3'b111
	} ecsd_stb_e;

	// cycle phase
	typedef enum logic [1:0] {
		ECSD_IDLE = 2'b00,
		ECSD_DATA = 2'b01,
		ECSD_DONE = 2'b10
	} ecsd_state_e;

	// one processor byte cycle
	typedef struct packed {
		logic [23:0] addr;
		logic        rd;
		logic        user;
		logic [7:0]  wdata;
	} ecsd_req_s;

	// active-low strobes toward the backplane
	typedef struct packed {
		logic read_data_strobe_n;
		logic write_data_strobe_n;
		logic status_strobe_n;
		logic read_aux_strobe_n;
		logic control_pulse_one_n;
		logic control_pulse_two_n;
		logic control_pulse_three_n;
		logic control_pulse_four_n;
		logic scanner_strobe_n;
	} ecsd_stb_s;

	localparam ecsd_stb_s ECSD_STB_IDLE = '1;

endpackage : ecsd_pkg

//--- test/ecsd_decoder_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ecsd_chk
	import ecsd_pkg::*;
#(
	parameter int CARDS = ECSD_CARDS
) (
	// clock, reset and request side
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       cyc_i,
	input wire ecsd_req_s  req_i,
	input wire logic       port_b_perm_i,
	// decoder outputs
	input wire logic       ack_o,
	input wire logic       gen_hit_o,
	input wire logic       permit_n_o,
	input wire ecsd_stb_s  stb_o,
	input wire logic [5:0] card_sel_o,
	input wire logic       byte_clk_o,
	input wire logic [3:0] direct_level_o,
	input wire logic       interrupt_request_level_zero_o,
	input wire logic       dma_grant_floppy_o,
	input wire logic       dma_grant_card_o
);
	// single domain, so one clocking and one disable for all
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	strobe_len_a: assert property ($fell(&stb_o) |-> (!(&stb_o))[*3] ##1 ack_o)
		else $error("strobe not held three cycles up to ack");
	strobe_rel_a: assert property (ack_o |-> &stb_o)
		else $error("strobe still low in ack cycle");
	one_strobe_a: assert property ($onehot0(~stb_o))
		else $error("more than one strobe low");
	even_refuse_a: assert property (cyc_i && !req_i.addr[0] |=> ack_o && &stb_o)
		else $error("even address not refused at once");
	user_block_a: assert property (cyc_i && req_i.user && !port_b_perm_i |=> permit_n_o)
		else $error("permit given to user without permission");
	sys_permit_a: assert property (cyc_i && !req_i.user && req_i.addr[1:0] == 2'b01
		&& req_i.addr[23:17] == 7'h7F |=> !permit_n_o)
		else $error("permit missing in system mode");
	gen_area_a: assert property (cyc_i && req_i.addr[23:22] == 2'b01 |=> gen_hit_o)
		else $error("general area not decoded");
	slot_sel_a: assert property ($fell(&stb_o) |-> byte_clk_o
		&& card_sel_o == $past(req_i.addr[16:11]))
		else $error("card select or byte clock wrong at strobe");
	scan_kind_a: assert property ($fell(stb_o.scanner_strobe_n)
		|-> $past(req_i.addr[6]) && $past(req_i.addr[4]))
		else $error("scanner strobe outside special high cycle");
	byte_pulse_a: assert property (byte_clk_o |=> !byte_clk_o)
		else $error("byte clock longer than one cycle");
	irq_zero_a: assert property (interrupt_request_level_zero_o == |direct_level_o)
		else $error("level zero not the sum of direct levels");
	dma_one_a: assert property (!(dma_grant_floppy_o && dma_grant_card_o))
		else $error("both DMA owners granted");
endmodule : ecsd_chk

bind ecsd_decoder ecsd_chk #(.CARDS(CARDS)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.cyc_i(cyc_i), .req_i(req_i), .port_b_perm_i(port_b_perm_i), .ack_o(ack_o),
	.gen_hit_o(gen_hit_o), .permit_n_o(permit_n_o), .stb_o(stb_o),
	.card_sel_o(card_sel_o), .byte_clk_o(byte_clk_o),
	.direct_level_o(direct_level_o),
	.interrupt_request_level_zero_o(interrupt_request_level_zero_o),
	.dma_grant_floppy_o(dma_grant_floppy_o), .dma_grant_card_o(dma_grant_card_o));
`default_nettype wire

//--- test/ecsd_cards.sv
`timescale 1ns/10ps
`default_nettype none
module ecsd_cards
	import ecsd_pkg::*;
(
	// from the decoder
	input  wire logic       clk_i,
	input  wire ecsd_stb_s  stb_i,
	input  wire logic [5:0] card_sel_i,
	input  wire logic       chan_sel_i,
	input  wire logic       permit_n_i,
	// toward the decoder
	output logic [7:0]      card_rdata_o,
	output logic [3:0]      presence_n_o
);
	logic [7:0] last_q;
	logic       rd_act;
	// a card or the scanner answers only under permit with its strobe low
	assign rd_act = !permit_n_i && !(stb_i.read_data_strobe_n
		&& stb_i.status_strobe_n && stb_i.read_aux_strobe_n
		&& stb_i.scanner_strobe_n);
	// slot number plus channel bit; released lanes toggle so stale data fails
	assign card_rdata_o = rd_act ? {chan_sel_i, 1'b1, card_sel_i} : ~last_q;
	always_ff @(posedge clk_i) begin
		last_q <= card_rdata_o;
	end
	// per-slot presence wiring, low nibble of the slot number
	assign presence_n_o = card_sel_i[3:0];
endmodule : ecsd_cards
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
	import ecsd_pkg::*;
;
	logic        clk_i = 1'b0, rst_n_i = 1'b0, cyc_i = 1'b0, perm = 1'b0;
	ecsd_req_s   req_i = '0;
	logic [63:0] open_i = 64'hFFFF_FFFF_FFFF_FFF7;
	logic [3:0]  irq_n = 4'hF;
	logic        l5_n = 1'b1, l2_n = 1'b1, df = 1'b0, dc = 1'b0, dd = 1'b0;
	logic        ack, pn, bclk, chan, i0, i5, i2, gf, gc, wh, gh;
	logic [1:0]  snm;
	logic [7:0]  rdata, crd, wdo;
	logic [5:0]  csel;
	logic [3:0]  lvl, pres_n;
	ecsd_stb_s   stb, s;
	wire [8:0]   obs = {lvl, i0, i5, i2, gf, gc};
	int          fail_count = 0, n_compared = 0, n;
	int          sn[8] = '{0, 1, 2, 0, 2, 3, 4, 5};
	int          bi[8] = '{8, 6, 5, 7, 4, 3, 2, 1};

	always #20 clk_i = ~clk_i;

	// decoder and card model
	ecsd_decoder DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc_i), .req_i(req_i),
		.ack_o(ack), .win_hit_o(wh), .gen_hit_o(gh), .rdata_o(rdata),
		.port_b_perm_i(perm),
		.card_open_i(open_i), .permit_n_o(pn), .stb_o(stb), .card_sel_o(csel),
		.chan_sel_o(chan), .strobe_num_o(snm), .wdata_o(wdo), .byte_clk_o(bclk),
		.card_rdata_i(crd), .presence_n_i(pres_n), .direct_irq_n_i(irq_n),
		.interrupt_request_level_five_i(l5_n), .interrupt_request_level_two_i(l2_n),
		.direct_level_o(lvl), .interrupt_request_level_zero_o(i0),
		.interrupt_request_level_five_o(i5), .interrupt_request_level_two_o(i2),
		.dma_req_floppy_i(df), .dma_req_card_i(dc), .dma_done_i(dd),
		.dma_grant_floppy_o(gf), .dma_grant_card_o(gc));
	ecsd_cards u_cards (.clk_i(clk_i), .stb_i(stb), .card_sel_i(csel),
		.chan_sel_i(chan), .permit_n_i(pn), .card_rdata_o(crd), .presence_n_o(pres_n));

	task automatic give_verdict;
		$display("mismatches %0d, compares %0d", fail_count, n_compared);
		if (fail_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// one byte cycle; counts cycles to ack and keeps the strobe seen
	task automatic acc(input logic [23:0] a, input logic rd, input logic us,
		input logic [7:0] wd);
		s = ECSD_STB_IDLE;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		req_i <= '{a, rd, us, wd};
		@(posedge clk_i);
		cyc_i <= 1'b0;
		for (n = 1; n < 9; n++) begin
			#1;
			if (bclk === 1'b1) s = stb;
			if (ack === 1'b1) break;
			@(posedge clk_i);
		end
		if (n == 9) begin
			fail_count++;
			give_verdict();
		end
	endtask : acc

	task automatic try(input logic [23:0] a, input logic us, input logic [8:0] e);
		acc(a, 1'b1, us, 8'h00);
		// permit level at the ack beside the cycle count
		chk({pn, 8'(n)}, e);
	endtask : try

	// interrupt outputs pass a two-flop sync and DMA grants one flop, so poll with a bound
	task automatic wait_obs(input logic [8:0] e);
		int k;
		for (k = 0; k < 20 && obs !== e; k++) begin
			@(posedge clk_i);
			#1;
		end
		chk(obs, e);
		if (k == 20) give_verdict();
	endtask : wait_obs

	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// every standard strobe on slot 45, second channel
		for (int i = 0; i < 8; i++) begin
			acc(24'hFF_6881 + 24'(sn[i] * 4), i < 3, 1'b0, 8'hA5 ^ 8'(i));
			chk(9'(n), 9'h004);
			chk({5'h00, wh, gh, snm}, {5'h00, 2'b10, 2'(sn[i])});
			chk(s, ~(9'h001 << bi[i]));
			chk({2'b00, chan, csel}, 9'h06D);
			chk(i < 3 ? rdata : wdo, i < 3 ? 8'hED : 8'hA5 ^ 8'(i));
		end
		// slot 10: a data write, then special cycles: presence read, then scanner write and read
		acc(24'hFE_5001, 1'b0, 1'b0, 8'h00);
		acc(24'hFE_5045, 1'b1, 1'b0, 8'h00);
		chk(rdata, 9'h028);
		chk(s, ECSD_STB_IDLE);
		acc(24'hFE_5051, 1'b0, 1'b0, 8'h3C);
		chk(s, 9'h1FE);
		acc(24'hFE_5051, 1'b1, 1'b0, 8'h00);
		chk(s, 9'h1FE);
		chk(rdata, 9'h04A);
		// refusals and one permitted user cycle, then the general area edges
		try(24'hFE_5002, 1'b0, 9'h001);
		chk(rdata, 9'h000);
		try(24'hFD_0001, 1'b0, 9'h001);
		try(24'hFE_5001, 1'b1, 9'h101);
		perm <= 1'b1;
		try(24'hFE_1801, 1'b1, 9'h001);
		try(24'hFE_5001, 1'b1, 9'h104);
		acc(24'h40_0001, 1'b1, 1'b0, 8'h00);
		chk({7'h00, wh, gh}, 9'h001);
		acc(24'h7F_FFFF, 1'b1, 1'b0, 8'h00);
		chk({7'h00, wh, gh}, 9'h001);
		acc(24'h80_0001, 1'b1, 1'b0, 8'h00);
		chk({7'h00, wh, gh}, 9'h000);
		// interrupt levels, then DMA sharing with a tie
		irq_n <= 4'b1011;
		l5_n <= 1'b0;
		wait_obs(9'h098);
		irq_n <= 4'hF;
		l5_n <= 1'b1;
		l2_n <= 1'b0;
		wait_obs(9'h004);
		l2_n <= 1'b1;
		df <= 1'b1;
		dc <= 1'b1;
		wait_obs(9'h002);
		df <= 1'b0;
		dd <= 1'b1;
		@(posedge clk_i);
		dd <= 1'b0;
		wait_obs(9'h001);
		give_verdict();
	end
endmodule : tb
`default_nettype wire
